// *** hdl/gsp_driver.sv ***
// 24-channel 12-bit grayscale pwm driver core
// Behaviour
// - nonzero channels on fifth edge after unblank
// - shared 12-bit counter counts oscillator edges
// - channel off at level match or full count
// - period repeats while blanking stays low
// - no output turns on while blanked
// - latch strobe rising forces all outputs off
// - outputs resume next period with new levels
// - shift register and latch have no reset
// - works with blanking tied permanently low
// - twenty-four independent channel compares
// - shift register and latch hold 288 bits
// - capture on rising, msb out on falling
// - strobe rising copies shift register to latch
// - blanking forces outputs off, counter zero
`timescale 1ns/100ps
`default_nettype none
module gsp_driver
  import gsp_pkg::*;
(
  input  wire logic         sys_clk,         // internal oscillator clock
  input  wire logic         arst_n,          // async reset, active low
  input  wire logic         serial_clk,      // serial shift clock from host
  input  wire logic         serial_data_in,  // serial grayscale bit
  input  wire logic         latch_strobe,    // latch strobe pin
  input  wire logic         blank,           // blanking pin, high = all off
  output logic              serial_data_out, // cascade output, falling edge
  output logic [NUM_CH-1:0] channel_sink     // channel sink enables
);

  // ****************************************************************
  // serial shift domain
  // ****************************************************************
  logic [SREG_BITS-1:0] sreg;
  logic [SREG_BITS-1:0] next_sreg;

  always_comb
  begin
    next_sreg = {sreg[SREG_BITS-2:0], serial_data_in};
  end

  // no reset: contents undefined until shifted in
  always_ff @(posedge serial_clk)
  begin
    sreg <= next_sreg;
  end

  always_ff @(negedge serial_clk or negedge arst_n)
  begin
    if (!arst_n)
      serial_data_out <= 1'h0;
    else
      serial_data_out <= sreg[SREG_BITS-1];
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic blank_meta;
  logic blank_q;
  logic latch_meta;
  logic latch_q;
  logic latch_d;
  logic latch_rise;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      blank_meta <= BLANK_RST;
      blank_q    <= BLANK_RST;
      latch_meta <= LATCH_RST;
      latch_q    <= LATCH_RST;
      latch_d    <= LATCH_RST;
    end
    else
    begin
      blank_meta <= blank;
      blank_q    <= blank_meta;
      latch_meta <= latch_strobe;
      latch_q    <= latch_meta;
      latch_d    <= latch_q;
    end
  end

  assign latch_rise = latch_q && !latch_d;

  // ****************************************************************
  // latch loader: shift register words through the fifo
  // ****************************************************************
  logic      loading;
  logic      next_loading;
  logic [4:0] load_ch;
  logic [4:0] next_load_ch;
  logic      drain_slot;
  logic      next_drain_slot;
  gsp_word_t push_word;
  gsp_word_t pop_word;
  logic      push_ready;
  logic      pop_valid;
  logic      busy;

  always_comb
  begin
    next_loading    = loading;
    next_load_ch    = load_ch;
    next_drain_slot = !drain_slot;
    if (latch_rise)
    begin
      next_loading = 1'h1;
      next_load_ch = CH_ZERO;
    end
    else if (loading && push_ready)
    begin
      next_load_ch = load_ch + CH_STEP;
      if (load_ch == CH_LAST)
        next_loading = 1'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      loading    <= 1'h0;
      load_ch    <= CH_ZERO;
      drain_slot <= 1'h0;
    end
    else
    begin
      loading    <= next_loading;
      load_ch    <= next_load_ch;
      drain_slot <= next_drain_slot;
    end
  end

  // shift register is quiet while loading, read across as static words
  always_comb
  begin
    push_word.ch    = load_ch;
    push_word.level = sreg[load_ch*GS_BITS +: GS_BITS];
  end

  gsp_fifo #(
    .WIDTH ($bits(gsp_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (sys_clk),
    .arst_n    (arst_n),
    .in_valid  (loading),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (pop_valid),
    .out_ready (drain_slot),
    .out_data  (pop_word)
  );

  assign busy = loading || pop_valid;

  // ****************************************************************
  // grayscale latch
  // ****************************************************************
  logic [GS_BITS-1:0] level      [NUM_CH];
  logic [GS_BITS-1:0] next_level [NUM_CH];

  always_comb
  begin
    next_level = level;
    if (pop_valid && drain_slot)
      next_level[pop_word.ch] = pop_word.level;
  end

  // no reset: latch is undefined until loaded
  always_ff @(posedge sys_clk)
  begin
    level <= next_level;
  end

  // ****************************************************************
  // pwm timing controller
  // ****************************************************************
  gsp_state_t         state;
  gsp_state_t         next_state;
  logic [2:0]         dly;
  logic [2:0]         next_dly;
  logic [GS_BITS-1:0] cnt;
  logic [GS_BITS-1:0] next_cnt;
  logic               hold;
  logic               next_hold;
  logic [NUM_CH-1:0]  next_sink;
  logic               next_run;

  always_comb
  begin
    next_state = state;
    next_dly   = dly;
    next_cnt   = cnt;
    next_hold  = hold;
    unique case (state)
      ST_BLANK:
      begin
        next_dly = DLY_ZERO;
        if (!blank_q)
          next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        next_dly = dly + DLY_STEP;
        if (dly == ON_DELAY - 3'h2)
          next_state = ST_RUN;
      end
      ST_RUN:
      begin
        next_cnt = cnt + CNT_STEP;
      end
    endcase
    if (blank_q)
    begin
      next_state = ST_BLANK;
      next_cnt   = CNT_ZERO;
    end
    if (latch_rise)
      next_hold = 1'h1;
    else if (hold && !busy && (state != ST_RUN || cnt == CNT_MAX))
      next_hold = 1'h0;
    next_run = (next_state == ST_RUN);
  end

  generate
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
      assign next_sink[g] = next_run && !next_hold && (next_level[g] > next_cnt);
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state        <= ST_BLANK;
      dly          <= DLY_ZERO;
      cnt          <= CNT_ZERO;
      hold         <= 1'h0;
      channel_sink <= SINK_RST;
    end
    else
    begin
      state        <= next_state;
      dly          <= next_dly;
      cnt          <= next_cnt;
      hold         <= next_hold;
      channel_sink <= next_sink;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [NUM_CH-1:0] dark_mask;

  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
      dark_mask[i] = (level[i] == CNT_ZERO);
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  chk_unblank_delay: assert property (
    $fell(blank_q) ##1 (!blank_q)[*4] |-> (state != ST_RUN) ##1 (state == ST_RUN))
    else $error("outputs not enabled on fifth edge after unblank");

  chk_cnt_step: assert property (
    (state == ST_RUN) && !blank_q |=> (cnt == $past(cnt) + CNT_STEP))
    else $error("shared counter did not advance by one");

  chk_off_full: assert property (
    (cnt == CNT_MAX) |-> (channel_sink == SINK_RST))
    else $error("channel on at full count");

  chk_cnt_wrap: assert property (
    (state == ST_RUN) && (cnt == CNT_MAX) && !blank_q |=> (cnt == CNT_ZERO) && (state == ST_RUN))
    else $error("period did not repeat");

  chk_blank_dark: assert property (
    blank_q |=> (channel_sink == SINK_RST) && (cnt == CNT_ZERO))
    else $error("output or counter active while blanked");

  chk_latch_off: assert property (
    latch_rise |=> (channel_sink == SINK_RST) && hold)
    else $error("latch strobe did not force outputs off");

  chk_hold_release: assert property (
    $fell(hold) |-> (cnt == CNT_ZERO) || (state != ST_RUN))
    else $error("outputs resumed mid period");

  chk_dark_zero: assert property (
    (channel_sink & dark_mask) == SINK_RST)
    else $error("zero level channel turned on");

  chk_load_done: assert property (
    $rose(loading) |-> ##[24:60] !busy)
    else $error("latch load did not finish");

  chk_no_clear: assert property (
    latch_rise && (state == ST_RUN) && !blank_q && (cnt != CNT_MAX) |=> (cnt != CNT_ZERO))
    else $error("latch strobe cleared counter");

  cov_run_wrap: cover property ((state == ST_RUN) && (cnt == CNT_MAX));
  cov_latch_run: cover property (latch_rise && (state == ST_RUN));
  cov_unblank: cover property ($fell(blank_q) ##5 (state == ST_RUN));
  cov_fifo_full: cover property (loading && !push_ready);

endmodule
`default_nettype wire

// *** hdl/gsp_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module gsp_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,       // fifo clock
  input  wire logic             arst_n,    // async reset, active low
  input  wire logic             in_valid,  // write request
  output logic                  in_ready,  // space available
  input  wire logic [WIDTH-1:0] in_data,   // write word
  output logic                  out_valid, // word available
  input  wire logic             out_ready, // reader takes word
  output logic      [WIDTH-1:0] out_data   // head word
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_DEPTH = (AW+1)'(DEPTH);
  localparam logic [AW:0] CNT_ONE   = (AW+1)'(1);
  localparam logic [AW-1:0] PTR_ONE = AW'(1);
  localparam logic [AW-1:0] PTR_END = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_fill;
  logic             push;
  logic             pop;

  // ****************************************************************
  // pointer and fill update
  // ****************************************************************
  always_comb
  begin
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_fill   = fill;
    if (push)
      next_wr_ptr = (wr_ptr == PTR_END) ? '0 : wr_ptr + PTR_ONE;
    if (pop)
      next_rd_ptr = (rd_ptr == PTR_END) ? '0 : rd_ptr + PTR_ONE;
    if (push && !pop)
      next_fill = fill + CNT_ONE;
    else if (pop && !push)
      next_fill = fill - CNT_ONE;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill   <= next_fill;
    end
  end

  // storage is data only and needs no reset
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  assign in_ready  = (fill != CNT_DEPTH);
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];

endmodule
`default_nettype wire

// *** hdl/gsp_pkg.sv ***
// shared constants and types for the grayscale pwm driver
package gsp_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int          NUM_CH     = 24;
  localparam int          GS_BITS    = 12;
  localparam int          SREG_BITS  = NUM_CH * GS_BITS;
  localparam int          CH_BITS    = 5;
  localparam int          FIFO_DEPTH = 4;

  // ****************************************************************
  // counter and timing
  // ****************************************************************
  localparam logic [11:0] CNT_ZERO   = 12'h000;
  localparam logic [11:0] CNT_STEP   = 12'h001;
  localparam logic [11:0] CNT_MAX    = 12'hFFF;
  localparam logic [2:0]  ON_DELAY   = 3'h5;
  localparam logic [2:0]  DLY_ZERO   = 3'h0;
  localparam logic [2:0]  DLY_STEP   = 3'h1;
  localparam logic [4:0]  CH_ZERO    = 5'h00;
  localparam logic [4:0]  CH_STEP    = 5'h01;
  localparam logic [4:0]  CH_LAST    = 5'h17;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic        BLANK_RST  = 1'h1;
  localparam logic        LATCH_RST  = 1'h0;
  localparam logic [23:0] SINK_RST   = 24'h000000;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {ST_BLANK, ST_WAIT, ST_RUN} gsp_state_t;

  typedef struct packed {
    logic [4:0]  ch;
    logic [11:0] level;
  } gsp_word_t;

endpackage

// *** verification/gsp_driver_tb.sv ***
// self-checking bench for the grayscale pwm driver
`timescale 1ns/100ps
`default_nettype none
module gsp_driver_tb
  import gsp_pkg::*;
;
  logic              sys_clk;
  logic              arst_n;
  logic              serial_clk;
  logic              serial_data_in;
  logic              latch_strobe;
  logic              blank;
  logic              serial_data_out;
  logic [NUM_CH-1:0] channel_sink;
  int                mismatches = 0;
  int                checked = 0;
  int                cycles = 0;
  int                n;

  gsp_driver i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .latch_strobe(latch_strobe), .blank(blank),
    .serial_data_out(serial_data_out), .channel_sink(channel_sink));
  gsp_host i_host (.sys_clk(sys_clk), .serial_data_out(serial_data_out),
    .serial_clk(serial_clk), .serial_data_in(serial_data_in),
    .latch_strobe(latch_strobe), .blank(blank));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input logic [SREG_BITS-1:0] seen, input logic [SREG_BITS-1:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic logic [11:0] lvl(input int c, input logic v);
    logic [11:0] b;
    b = (c == 0) ? CNT_ZERO : (c == 1) ? CNT_STEP : (c == NUM_CH - 1) ? CNT_MAX
      : 12'(c * 12'h0AB);
    return v ? ~b : b;
  endfunction
  function automatic logic [SREG_BITS-1:0] img(input logic v);
    logic [SREG_BITS-1:0] r;
    for (int c = 0; c < NUM_CH; c++)
      r[GS_BITS*c +: GS_BITS] = lvl(c, v);
    return r;
  endfunction
  task automatic wait_sink(input logic any, output int k);
    k = 0;
    while ((|channel_sink) !== any && k < 5000)
    begin
      @(negedge sys_clk);
      k++;
    end
  endtask
  // on-time per channel over whole periods, from a period start
  task automatic measure(input logic v, input int periods);
    logic [31:0] on [NUM_CH];
    for (int p = 0; p < periods; p++)
    begin
      foreach (on[c]) on[c] = 32'h0;
      repeat (4096)
      begin
        foreach (on[c]) on[c] += channel_sink[c];
        @(negedge sys_clk);
      end
      foreach (on[c]) check(on[c], lvl(c, v));
    end
  endtask
  task automatic hold_off(input int len);
    logic [NUM_CH-1:0] acc;
    acc = SINK_RST;
    repeat (len)
    begin
      acc |= channel_sink;
      @(negedge sys_clk);
    end
    check(acc, SINK_RST);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_load;
    i_host.load(img(1'h1));
    i_host.load(img(1'h0));
    check(i_host.echo, img(1'h1));
    i_host.strobe();
    hold_off(200);
    $display("test load done");
  endtask
  task automatic t_unblank;
    i_host.set_blank(1'h0);
    wait_sink(1'h1, n);
    check(n >= 6 && n <= 8, 1'h1);
    measure(1'h0, 2);
    $display("test unblank done");
  endtask
  task automatic t_strobe;
    repeat (1000) @(negedge sys_clk);
    i_host.load(img(1'h1));
    fork
      i_host.strobe();
      wait_sink(1'h0, n);
    join
    check(n <= 6, 1'h1);
    wait_sink(1'h1, n);
    check(n > 1000 && n < 4000, 1'h1);
    measure(1'h1, 1);
    $display("test strobe done");
  endtask
  task automatic t_blank;
    logic [NUM_CH-1:0] mask;
    foreach (mask[c]) mask[c] = (lvl(c, 1'h1) != CNT_ZERO);
    repeat (1000) @(negedge sys_clk);
    i_host.set_blank(1'h1);
    repeat (3) @(negedge sys_clk);
    hold_off(300);
    i_host.set_blank(1'h0);
    wait_sink(1'h1, n);
    check(channel_sink, mask);
    measure(1'h1, 1);
    $display("test blank done");
  endtask

  initial
  begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      conclude();
    end
  end
  initial
  begin
    arst_n = 1'h0;
    repeat (16) @(negedge sys_clk);
    arst_n = 1'h1;
    t_load();
    t_unblank();
    t_strobe();
    t_blank();
    conclude();
  end
endmodule
`default_nettype wire

// *** verification/gsp_host.sv ***
// host model: serial shift, latch strobe and blanking
`timescale 1ns/100ps
`default_nettype none
module gsp_host
  import gsp_pkg::*;
(
  input  wire logic sys_clk,         // oscillator clock
  input  wire logic serial_data_out, // cascade bit back
  output logic      serial_clk,      // shift clock
  output logic      serial_data_in,  // serial bit
  output logic      latch_strobe,    // latch strobe
  output logic      blank            // blanking level
);
  logic [SREG_BITS-1:0] echo;
  initial
  begin
    serial_clk = 1'h0;
    serial_data_in = 1'h0;
    latch_strobe = 1'h0;
    blank = 1'h1;
  end
  // quiet gap, then msb first; echo takes the outgoing msb before each rise
  task automatic load(input logic [SREG_BITS-1:0] img);
    repeat (70) @(negedge sys_clk);
    #3.7;
    for (int i = SREG_BITS - 1; i >= 0; i--)
    begin
      serial_data_in = img[i];
      #5 echo[i] = serial_data_out;
      serial_clk = 1'h1;
      #6 serial_clk = 1'h0;
      #1;
    end
    serial_data_in = ~serial_data_in;
  endtask
  task automatic strobe;
    @(negedge sys_clk) latch_strobe = 1'h1;
    repeat (3) @(negedge sys_clk);
    latch_strobe = 1'h0;
  endtask
  task automatic set_blank(input logic v);
    @(negedge sys_clk) blank = v;
  endtask
endmodule
`default_nettype wire
